// File: wake_pkg.sv
// Constants, register map and carrier types of the wake manager.
package wake_pkg;

  // Clock and filter timing.
  localparam int CLK_NS = 25;
  localparam int CNT_W = 11;
  localparam int PFT_5_NS = 5000;
  localparam int PFT_10_NS = 10000;
  localparam int PFT_20_NS = 20000;
  localparam int PFT_40_NS = 40000;
  localparam int MFT_20_NS = 20000;
  localparam int MFT_40_NS = 40000;
  localparam int LFT_30_NS = 30000;
  localparam int LFT_50_NS = 50000;
  localparam logic [CNT_W-1:0] PFT_5_CYC = CNT_W'((PFT_5_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] PFT_10_CYC = CNT_W'((PFT_10_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] PFT_20_CYC = CNT_W'((PFT_20_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] PFT_40_CYC = CNT_W'((PFT_40_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] MFT_20_CYC = CNT_W'((MFT_20_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] MFT_40_CYC = CNT_W'((MFT_40_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] LFT_30_CYC = CNT_W'((LFT_30_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] LFT_50_CYC = CNT_W'((LFT_50_NS + CLK_NS - 1) / CLK_NS);

  // Register byte addresses.
  localparam logic [7:0] MAIN_STS_OFS = 8'h00;
  localparam logic [7:0] PORT_STS_OFS = 8'h04;
  localparam logic [7:0] LIN_EN_OFS = 8'h50;
  localparam logic [7:0] FILT_OFS = 8'hAC;
  localparam logic [7:0] P0_CFG_OFS = 8'hC8;
  localparam logic [7:0] P1_CFG_OFS = 8'hCC;
  localparam logic [7:0] MON_CFG_OFS = 8'hD0;

  // Field positions.
  localparam int LIN_BIT = 0;
  localparam int MON_SUM_BIT = 1;
  localparam int P0_SUM_BIT = 2;
  localparam int P1_SUM_BIT = 3;
  localparam int CYC_BIT = 4;
  localparam int FAIL_BIT = 5;
  localparam int P2_SUM_BIT = 6;
  localparam int MON_FLAG_LSB = 8;
  localparam int AUX_OT_BIT = 17;
  localparam int AUX_UV_BIT = 18;
  localparam int LIN_EN_BIT = 7;
  localparam int RISE_LSB = 0;
  localparam int FALL_LSB = 8;
  localparam int CYC_LSB = 16;
  localparam int PFT_LSB = 2;
  localparam int MFT_BIT = 1;
  localparam int LFT_BIT = 0;
  localparam int P0_FLAG_LSB = 0;
  localparam int P1_FLAG_LSB = 8;

  // Widths, masks and reset values.
  localparam int NPIN = 5;
  localparam int NFILT = 16;
  localparam int CFG_W = 21;
  localparam logic [CFG_W-1:0] CFG_MASK = 21'h1F1F1F;
  localparam logic [NPIN-1:0] P1_WAKE_MASK = 5'h17;
  localparam logic [31:0] REG_RST = 32'h00000000;

  typedef enum logic [1:0] {
    MODE_ACTIVE = 2'b00,
    MODE_STOP = 2'b01,
    MODE_SLEEP = 2'b10,
    MODE_STARTUP = 2'b11
  } power_mode_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  typedef struct packed {
    logic hs_ot;
    logic aux_ot;
    logic aux_uv;
    logic rst_n;
    logic lin;
    logic [NPIN-1:0] mon;
    logic [NPIN-1:0] port1;
    logic [NPIN-1:0] port0;
  } wake_pins_t;

endpackage

// File: wake_manager.sv
// Wake manager: filtered wake sources, wake status flags and configuration registers.
//
// Contract
// - Port 0 pins and port 1 pins 0, 1, 2, 4 wake from Stop on rising, falling or both edges; port 1 pin 3 never wakes.
// - Port pins never wake the device from Sleep.
// - Reset pin wakes from Stop, never from Sleep.
// - Monitor inputs wake on either edge from Stop and Sleep.
// - LIN wake has only its single enable.
// - Aux supply failure forces a wake from Stop.
// - High-side overtemperature forces a wake from Stop or Sleep.
// - Port 2 pins never raise a wake request.
// - Port 1 config: rising enables bits 4:0, falling enables 12:8.
// - Port 1 config: cyclic-sense selects in bits 20:16.
// - Port pin filter 3:2: 10, 20, 40, 5 us.
// - Monitor filter bit 1: 20 us clear, 40 us set.
// - LIN filter bit 0: 30 us clear, 50 us set.
// - LIN enable at bit 7; other bits read zero.
// - Main status bit 18 aux undervoltage, bit 17 aux overtemperature.
// - Monitor flags in bits 12:8; rh flags clear on read.
// - Bit 4 timed wake, bit 0 LIN wake, clear on read.
// - Summary bits 1, 2, 3 OR the per-pin flags; bit 6 (port 2) always reads zero.
// - Bit 5 shows a wake by aux supply failure.
// - Cyclic-sense inputs accepted only while the sense gate is high.
// - Port status: port 1 pins bits 8,9,10,12; port 0 bits 4:0.
// - Accepted wake starts the power manager's start-up sequence.
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps

module wake_manager (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Register port.
  input wire wake_pkg::bus_req_t bus_i,
  output logic [31:0] rdata_o,
  // Wake sources from pins.
  input wire wake_pkg::wake_pins_t pins_i,
  // Power and cyclic unit side.
  input wire wake_pkg::power_mode_t power_mode_i,
  input wire logic highside_sense_gate_i,
  input wire logic timed_wake_i,
  output logic wake_req_o
);
  import wake_pkg::*;

  typedef struct packed {
    wake_pins_t s1;
    wake_pins_t s2;
    logic [NFILT-1:0] stable;
    logic [NFILT-1:0][CNT_W-1:0] cnt;
    logic lin_en;
    logic [3:0] filt;
    logic [CFG_W-1:0] p0_cfg;
    logic [CFG_W-1:0] p1_cfg;
    logic [CFG_W-1:0] mon_cfg;
    logic [NPIN-1:0] p0_flag;
    logic [NPIN-1:0] p1_flag;
    logic [NPIN-1:0] mon_flag;
    logic lin_flag;
    logic cyc_flag;
    logic uv_flag;
    logic ot_flag;
    logic [31:0] rdata;
    logic wake;
  } state_t;

  state_t r;
  state_t n;

  ////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Filter length for input index i: 0-9 port pins, 10-14 monitors, 15 LIN.
  function automatic logic [CNT_W-1:0] filt_limit(input int i, input logic [3:0] f);
    logic [CNT_W-1:0] lim;
    lim = PFT_10_CYC;
    if (i == NFILT - 1) begin
      lim = f[LFT_BIT] ? LFT_50_CYC : LFT_30_CYC;
    end else if (i >= 2 * NPIN) begin
      lim = f[MFT_BIT] ? MFT_40_CYC : MFT_20_CYC;
    end else begin
      case (f[PFT_LSB +: 2])
        2'b00: lim = PFT_10_CYC;
        2'b01: lim = PFT_20_CYC;
        2'b10: lim = PFT_40_CYC;
        2'b11: lim = PFT_5_CYC;
        default: lim = PFT_10_CYC;
      endcase
    end
    return lim;
  endfunction

  // Edge qualification of one pin against its configuration word.
  function automatic logic edge_hit(input logic acc, input logic lvl,
                                    input logic [CFG_W-1:0] cfg, input int k,
                                    input logic gate);
    logic en;
    en = lvl ? cfg[RISE_LSB + k] : cfg[FALL_LSB + k];
    return acc & en & (~cfg[CYC_LSB + k] | gate);
  endfunction

  // Clear-on-read flag update: an event in the clearing read cycle keeps the flag set.
  function automatic logic [NPIN-1:0] flag_vec(input logic [NPIN-1:0] old_v, input logic clr,
                                               input logic [NPIN-1:0] ev);
    return (old_v & ~{NPIN{clr}}) | ev;
  endfunction

  function automatic logic flag_bit(input logic old_v, input logic clr, input logic ev);
    return (old_v & ~clr) | ev;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  always_comb begin
    logic [NFILT-1:0] cur;
    logic [NFILT-1:0] acc;
    logic [CNT_W-1:0] lim;
    logic [NPIN-1:0] p0_ev;
    logic [NPIN-1:0] p1_ev;
    logic [NPIN-1:0] mon_ev;
    logic stop;
    logic lowp;
    logic lin_ev;
    logic rst_ev;
    logic uv_ev;
    logic ot_ev;
    logic hs_ev;
    logic cyc_ev;
    logic rd_main;
    logic rd_port;
    logic [31:0] mux;
    cur = '0;
    acc = '0;
    lim = '0;
    p0_ev = '0;
    p1_ev = '0;
    mon_ev = '0;
    stop = 1'b0;
    lowp = 1'b0;
    lin_ev = 1'b0;
    rst_ev = 1'b0;
    uv_ev = 1'b0;
    ot_ev = 1'b0;
    hs_ev = 1'b0;
    cyc_ev = 1'b0;
    rd_main = 1'b0;
    rd_port = 1'b0;
    mux = REG_RST;
    n = r;

    // Two-stage synchronisers; only the second stage is read below.
    n.s1 = pins_i;
    n.s2 = r.s1;

    cur = {r.s2.lin, r.s2.mon, r.s2.port1, r.s2.port0};
    for (int i = 0; i < NFILT; i++) begin
      lim = filt_limit(i, r.filt);
      if (cur[i] != r.stable[i]) begin
        // A level must hold for the full filter before it is taken.
        if (r.cnt[i] >= lim - CNT_W'(1)) begin
          n.stable[i] = cur[i];
          n.cnt[i] = '0;
          acc[i] = 1'b1;
        end else begin
          n.cnt[i] = r.cnt[i] + CNT_W'(1);
        end
      end else begin
        // A glitch shorter than the filter restarts the count.
        n.cnt[i] = '0;
      end
    end

    stop = (power_mode_i == MODE_STOP);
    lowp = stop | (power_mode_i == MODE_SLEEP);

    for (int k = 0; k < NPIN; k++) begin
      p0_ev[k] = stop & edge_hit(acc[k], cur[k], r.p0_cfg, k, highside_sense_gate_i);
      p1_ev[k] = stop & P1_WAKE_MASK[k] &
                 edge_hit(acc[NPIN + k], cur[NPIN + k], r.p1_cfg, k, highside_sense_gate_i);
      mon_ev[k] = lowp &
                  edge_hit(acc[2 * NPIN + k], cur[2 * NPIN + k], r.mon_cfg, k, highside_sense_gate_i);
    end

    // LIN wake is the filtered start of a dominant (low) phase, taken once the filter expires.
    lin_ev = lowp & r.lin_en & acc[NFILT - 1] & ~cur[NFILT - 1];
    rst_ev = stop & ~r.s2.rst_n;
    uv_ev = stop & r.s2.aux_uv;
    ot_ev = stop & r.s2.aux_ot;
    hs_ev = lowp & r.s2.hs_ot;
    cyc_ev = lowp & timed_wake_i;

    // Port 2 has no input path, so it can never add to this sum.
    n.wake = |{p0_ev, p1_ev, mon_ev, lin_ev, rst_ev, uv_ev, ot_ev, hs_ev, cyc_ev};

    rd_main = bus_i.rd & (bus_i.addr == MAIN_STS_OFS);
    rd_port = bus_i.rd & (bus_i.addr == PORT_STS_OFS);

    // A source that fires in the clearing read cycle keeps its flag.
    n.mon_flag = flag_vec(r.mon_flag, rd_main, mon_ev);
    n.lin_flag = flag_bit(r.lin_flag, rd_main, lin_ev);
    n.cyc_flag = flag_bit(r.cyc_flag, rd_main, cyc_ev);
    n.uv_flag = flag_bit(r.uv_flag, rd_main, uv_ev);
    n.ot_flag = flag_bit(r.ot_flag, rd_main, ot_ev);
    n.p0_flag = flag_vec(r.p0_flag, rd_port, p0_ev);
    n.p1_flag = flag_vec(r.p1_flag, rd_port, p1_ev);

    if (bus_i.wr) begin
      case (bus_i.addr)
        LIN_EN_OFS: n.lin_en = bus_i.wdata[LIN_EN_BIT];
        FILT_OFS: n.filt = bus_i.wdata[3:0];
        P0_CFG_OFS: n.p0_cfg = bus_i.wdata[CFG_W-1:0] & CFG_MASK;
        P1_CFG_OFS: n.p1_cfg = bus_i.wdata[CFG_W-1:0] & CFG_MASK;
        MON_CFG_OFS: n.mon_cfg = bus_i.wdata[CFG_W-1:0] & CFG_MASK;
        default: n.filt = r.filt;
      endcase
    end

    case (bus_i.addr)
      MAIN_STS_OFS: begin
        mux[LIN_BIT] = r.lin_flag;
        mux[MON_SUM_BIT] = |r.mon_flag;
        mux[P0_SUM_BIT] = |r.p0_flag;
        mux[P1_SUM_BIT] = |r.p1_flag;
        mux[CYC_BIT] = r.cyc_flag;
        mux[FAIL_BIT] = r.uv_flag | r.ot_flag;
        mux[P2_SUM_BIT] = 1'b0;
        mux[MON_FLAG_LSB +: NPIN] = r.mon_flag;
        mux[AUX_OT_BIT] = r.ot_flag;
        mux[AUX_UV_BIT] = r.uv_flag;
      end
      PORT_STS_OFS: begin
        mux[P0_FLAG_LSB +: NPIN] = r.p0_flag;
        mux[P1_FLAG_LSB +: NPIN] = r.p1_flag & P1_WAKE_MASK;
      end
      LIN_EN_OFS: mux[LIN_EN_BIT] = r.lin_en;
      FILT_OFS: mux[3:0] = r.filt;
      P0_CFG_OFS: mux[CFG_W-1:0] = r.p0_cfg;
      P1_CFG_OFS: mux[CFG_W-1:0] = r.p1_cfg;
      MON_CFG_OFS: mux[CFG_W-1:0] = r.mon_cfg;
      default: mux = REG_RST;
    endcase
    // Read data stand for one cycle only; otherwise the port shows zero.
    n.rdata = bus_i.rd ? mux : REG_RST;
  end

  ////////////////////////////////////////////////////////////////////////
  // State register.

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign rdata_o = r.rdata;
  assign wake_req_o = r.wake;

endmodule

// File: wake_manager_sva.sv
// Port-level assertions of the wake manager.
`timescale 1ns/1ps
module wake_manager_sva
  import wake_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Observed ports.
  input wire wake_pkg::bus_req_t bus_i,
  input wire logic [31:0] rdata_o,
  input wire wake_pkg::wake_pins_t pins_i,
  input wire wake_pkg::power_mode_t power_mode_i,
  input wire logic highside_sense_gate_i,
  input wire logic timed_wake_i,
  input wire logic wake_req_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_lin_en_spare: assert property ($past(bus_i.rd && bus_i.addr == LIN_EN_OFS) |->
    {rdata_o[31:8], rdata_o[6:0]} == 31'h0) else $error("lin enable spare bits set");
  a_main_spare: assert property ($past(bus_i.rd && bus_i.addr == MAIN_STS_OFS) |->
    rdata_o[31:19] == 13'h0 && rdata_o[16:13] == 4'h0 && rdata_o[7:6] == 2'h0) else $error("main spare set");
  a_port_spare: assert property ($past(bus_i.rd && bus_i.addr == PORT_STS_OFS) |->
    rdata_o[31:13] == 19'h0 && !rdata_o[11] && rdata_o[7:5] == 3'h0) else $error("port spare set");
  a_cfg_spare: assert property ($past(bus_i.rd && bus_i.addr == P1_CFG_OFS) |->
    rdata_o[31:21] == 11'h0 && rdata_o[15:13] == 3'h0 && rdata_o[7:5] == 3'h0) else $error("cfg spare set");
  a_filt_spare: assert property ($past(bus_i.rd && bus_i.addr == FILT_OFS) |->
    rdata_o[31:4] == 28'h0) else $error("filter spare set");
  a_timed_wake: assert property (timed_wake_i && power_mode_i == MODE_STOP |->
    ##[1:3] wake_req_o) else $error("timed wake lost");
  a_active_quiet: assert property ((power_mode_i == MODE_ACTIVE) [*3] |->
    !wake_req_o) else $error("wake in active mode");
  a_aux_stop: assert property ((pins_i.aux_uv && power_mode_i == MODE_STOP) [*5] |->
    wake_req_o) else $error("aux fail no wake");
  a_hs_ot_sleep: assert property ((pins_i.hs_ot && power_mode_i == MODE_SLEEP) [*5] |->
    wake_req_o) else $error("overtemp no wake");
  a_rst_pin_stop: assert property ((!pins_i.rst_n && power_mode_i == MODE_STOP) [*5] |->
    wake_req_o) else $error("reset pin no wake");
endmodule
bind wake_manager wake_manager_sva wake_manager_sva_inst (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
  .bus_i(bus_i), .rdata_o(rdata_o), .pins_i(pins_i), .power_mode_i(power_mode_i),
  .highside_sense_gate_i(highside_sense_gate_i), .timed_wake_i(timed_wake_i), .wake_req_o(wake_req_o));

// File: wake_pins_model.sv
// Behavioural far side that drives the wake pins.
`timescale 1ns/1ps
module wake_pins_model
  import wake_pkg::*;
(
  // Clock.
  input wire logic ref_clk_i,
  // Pin levels.
  output wake_pkg::wake_pins_t pins_o
);
  // LIN idles recessive and the reset pin released, so neither looks like a wake at start.
  initial begin
    pins_o = '0;
    pins_o.rst_n = 1'b1;
    pins_o.lin = 1'b1;
  end
  task drive(input wake_pins_t v);
    @(posedge ref_clk_i);
    pins_o <= v;
  endtask
endmodule

// File: wake_manager_tb.sv
// Self-checking testbench of the wake manager.
`timescale 1ns/1ps
module wake_manager_tb;
  import wake_pkg::*;
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] e;} row_t;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  bus_req_t bus = '0;
  logic [31:0] rdata_o;
  wake_pins_t pins;
  wake_pins_t pv;
  power_mode_t mode = MODE_ACTIVE;
  logic timed = 1'b0;
  logic gate = 1'b0;
  logic wake_req_o;
  logic [31:0] got;
  int mismatches = 0;
  int samples_checked = 0;
  // Write rows always write all ones, so spare bits must read back as zero.
  row_t rows [12] = '{'{1'b0, MAIN_STS_OFS, 32'h0}, '{1'b0, PORT_STS_OFS, 32'h0},
    '{1'b0, LIN_EN_OFS, 32'h0}, '{1'b0, FILT_OFS, 32'h0}, '{1'b0, P0_CFG_OFS, 32'h0},
    '{1'b0, P1_CFG_OFS, 32'h0}, '{1'b1, LIN_EN_OFS, 32'h80}, '{1'b1, FILT_OFS, 32'hF},
    '{1'b1, P1_CFG_OFS, 32'h1F1F1F}, '{1'b1, P0_CFG_OFS, 32'h1F1F1F},
    '{1'b1, PORT_STS_OFS, 32'h0}, '{1'b1, 8'h10, 32'h0}};
  always #12.5 ref_clk_i = ~ref_clk_i;
  wake_manager wake_manager_inst (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .bus_i(bus), .rdata_o(rdata_o),
    .pins_i(pins), .power_mode_i(mode), .highside_sense_gate_i(gate), .timed_wake_i(timed),
    .wake_req_o(wake_req_o));
  wake_pins_model wake_pins_model_inst (.ref_clk_i(ref_clk_i), .pins_o(pins));
  ////////////////////////////////////////
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk_i);
    bus.wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge ref_clk_i);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge ref_clk_i);
    bus.rd <= 1'b0;
    #1 got = rdata_o;
  endtask
  task wake(input string n, input int lo, input int hi, input logic e);
    int c;
    c = 0;
    #1;
    while (wake_req_o !== 1'b1 && c < hi) begin
      @(posedge ref_clk_i);
      #1 c++;
    end
    chk(n, {31'h0, e}, {31'h0, wake_req_o === 1'b1 && c >= lo});
    $display("test %s done", n);
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (10000) @(posedge ref_clk_i);
    mismatches++;
    final_report;
  end
  initial begin
    pv = '0;
    pv.rst_n = 1'b1;
    pv.lin = 1'b1;
    repeat (5) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, 32'hFFFFFFFF);
      rd(rows[i].a);
      chk("register", rows[i].e, got);
    end
    $display("test registers done");
    wr(FILT_OFS, 32'h0000000C);
    wr(P0_CFG_OFS, 32'h00020007);
    wr(MON_CFG_OFS, 32'h00000001);
    wr(LIN_EN_OFS, 32'h00000080);
    mode <= MODE_STOP;
    pv.port0[0] = 1'b1;
    wake_pins_model_inst.drive(pv);
    wake("port rise", 195, 215, 1'b1);
    rd(MAIN_STS_OFS);
    chk("main", 32'h4, got);
    rd(PORT_STS_OFS);
    chk("port", 32'h1, got);
    rd(PORT_STS_OFS);
    chk("port", 32'h0, got);
    pv.port0[2] = 1'b1;
    wake_pins_model_inst.drive(pv);
    repeat (100) @(posedge ref_clk_i);
    pv.port0[2] = 1'b0;
    wake_pins_model_inst.drive(pv);
    wake("glitch", 0, 300, 1'b0);
    pv.port0[1] = 1'b1;
    wake_pins_model_inst.drive(pv);
    wake("gate low", 0, 300, 1'b0);
    @(posedge ref_clk_i);
    gate <= 1'b1;
    pv.port1[4:3] = 2'b11;
    wake_pins_model_inst.drive(pv);
    wake("gate high", 195, 215, 1'b1);
    rd(PORT_STS_OFS);
    chk("port", 32'h00001000, got);
    pv.port1[4] = 1'b0;
    wake_pins_model_inst.drive(pv);
    wake("port fall", 195, 215, 1'b1);
    rd(PORT_STS_OFS);
    chk("port", 32'h00001000, got);
    @(posedge ref_clk_i);
    mode <= MODE_SLEEP;
    pv.port0[2] = 1'b1;
    wake_pins_model_inst.drive(pv);
    wake("sleep port", 0, 300, 1'b0);
    pv.mon[0] = 1'b1;
    wake_pins_model_inst.drive(pv);
    wake("monitor", 795, 815, 1'b1);
    rd(MAIN_STS_OFS);
    chk("main", 32'h102, got);
    rd(MAIN_STS_OFS);
    chk("main", 32'h0, got);
    pv.hs_ot = 1'b1;
    wake_pins_model_inst.drive(pv);
    wake("overtemp", 0, 6, 1'b1);
    repeat (4) @(posedge ref_clk_i);
    pv.hs_ot = 1'b0;
    wake_pins_model_inst.drive(pv);
    // Let the synchronised overtemperature pulses drain before the next wake is timed.
    repeat (4) @(posedge ref_clk_i);
    mode <= MODE_STOP;
    pv.lin = 1'b0;
    wake_pins_model_inst.drive(pv);
    wake("lin", 1195, 1215, 1'b1);
    pv.lin = 1'b1;
    wake_pins_model_inst.drive(pv);
    rd(MAIN_STS_OFS);
    chk("main", 32'h1, got);
    @(posedge ref_clk_i);
    timed <= 1'b1;
    @(posedge ref_clk_i);
    timed <= 1'b0;
    wake("timed", 0, 4, 1'b1);
    rd(MAIN_STS_OFS);
    chk("main", 32'h10, got);
    pv.aux_uv = 1'b1;
    pv.aux_ot = 1'b1;
    wake_pins_model_inst.drive(pv);
    wake("aux supply", 0, 6, 1'b1);
    repeat (4) @(posedge ref_clk_i);
    pv.aux_uv = 1'b0;
    pv.aux_ot = 1'b0;
    wake_pins_model_inst.drive(pv);
    repeat (4) @(posedge ref_clk_i);
    rd(MAIN_STS_OFS);
    chk("main", 32'h00060020, got);
    pv.rst_n = 1'b0;
    wake_pins_model_inst.drive(pv);
    wake("reset pin", 0, 6, 1'b1);
    repeat (4) @(posedge ref_clk_i);
    pv.rst_n = 1'b1;
    wake_pins_model_inst.drive(pv);
    repeat (4) @(posedge ref_clk_i);
    // Leave Stop first: the reset-pin synchroniser restarts low after a reset.
    mode <= MODE_ACTIVE;
    rst_n_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    chk("wake after reset", 32'h0, {31'h0, wake_req_o});
    rd(LIN_EN_OFS);
    chk("lin enable", 32'h0, got);
    $display("test reset done");
    final_report;
  end
endmodule
